// *** verilog/serdes_config_register_bank.sv ***
// serdes configuration registers behind a clause 45 management slave
// assumes mdc and mdio arrive as pins; the station samples mdio on mdc rise
//
// Summary of operation
// - jog mode: input pulses jog, else level enables alignment
// - rate field: full, half, quarter; 11 reserved
// - width bit: clear 10-bit, set 8-bit
// - loop bandwidth bit: 0 high, 1 low
// - multiplier codes 5,25,10,15,4,20,8; 111 reserved
// - enable bits 15:8 gate transmit pairs
// - enable bits 7:0 gate receive pairs
// - global power-down disables all lanes
// - side power-down disables its four lanes
// - power-down overrides per-lane enable bits
// - low nibbles side a, high nibbles side b
// - comma-detect status bits read fixed value
// - loss-of-link status bits read fixed value
// - fail select routes a test failure source
// - primary select: set side a, clear b
`timescale 1ns/1ps
module serdes_config_register_bank #(
  parameter logic [4:0] PORT_ADDR = 5'h00
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  input wire logic [7:0] perLaneAlignControl,
  input wire logic [1:0] testFailSrc,
  output logic [7:0] commaAlignEn,
  output logic [7:0] alignJog,
  output logic jogModeSelect,
  output logic [1:0] serialRateSelect,
  output logic byteWidthSelect,
  output logic loopBandwidthLow,
  output logic [2:0] multiplierSelect,
  output logic [4:0] multFactor,
  output logic pllEnable,
  output logic serdesPowerDown,
  output logic [7:0] txPairEn,
  output logic [7:0] rxPairEn,
  output logic primarySideA,
  output logic failOut
);
  typedef enum logic [1:0] {PRE, HDR, TURN, DATA} frame_t;

  frame_t state_r;
  logic [9:0] pinRaw;
  logic [9:0] pinSync;
  logic mdcS;
  logic mdioS;
  logic [7:0] jogS;
  logic mdcPrev_r;
  logic mdcRise;
  logic [5:0] preCnt_r;
  logic [4:0] bitCnt_r;
  logic [15:0] shift_r;
  logic [15:0] rdShift_r;
  logic [15:0] addr_r;
  logic [1:0] op_r;
  logic [13:0] hdrWord;
  logic hdrMatch;
  logic [15:0] wrData;
  logic wrEn;
  logic [15:0] rdWord;
  logic [15:0] ctrl_r;
  logic [15:0] cfg2_r;
  logic [15:0] laneEn_r;
  logic [15:0] pll_r;
  logic [15:0] fail_r;
  logic [15:0] redun_r;
  logic [1:0] rateNxt;
  logic [2:0] mulNxt;
  logic [7:0] jogPrev_r;
  logic [7:0] commaAlignEn_r;
  logic [7:0] alignJog_r;
  logic [4:0] multFactor_r;
  logic failOut_r;

  function automatic logic [4:0] mulFactor(input logic [2:0] code);
    case (code)
      3'h0: mulFactor = 5'h05;
      3'h1: mulFactor = 5'h19;
      3'h2: mulFactor = 5'h0A;
      3'h3: mulFactor = 5'h0F;
      3'h4: mulFactor = 5'h04;
      3'h5: mulFactor = 5'h14;
      3'h6: mulFactor = 5'h08;
      default: mulFactor = 5'h00;
    endcase
  endfunction

  assign pinRaw = {perLaneAlignControl, mdioIn, mdc};

  pin_sync #(.WIDTH(10)) uSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(pinRaw),
    .pinOut(pinSync)
  );

  assign mdcS = pinSync[0];
  assign mdioS = pinSync[1];
  assign jogS = pinSync[9:2];
  assign mdcRise = mdcS & ~mdcPrev_r;

  // header bits: st(2) op(2) port(5) devad(5); the first st bit is the zero that ended the preamble
  assign hdrWord = {shift_r[12:0], mdioS};
  assign hdrMatch = hdrWord[13:12] == 2'h0 && hdrWord[9:5] == PORT_ADDR &&
    (hdrWord[4:0] == serdes_cfg_pkg::DEVAD_A || hdrWord[4:0] == serdes_cfg_pkg::DEVAD_B);
  assign wrData = {shift_r[14:0], mdioS};
  assign wrEn = mdcRise && state_r == DATA && bitCnt_r == serdes_cfg_pkg::DATA_LAST &&
    op_r == serdes_cfg_pkg::OP_WRITE;

  always_comb begin
    unique case (addr_r)
      serdes_cfg_pkg::ADDR_CTRL: rdWord = ctrl_r;
      serdes_cfg_pkg::ADDR_CFG2: rdWord = cfg2_r;
      serdes_cfg_pkg::ADDR_LANE_EN: rdWord = laneEn_r;
      serdes_cfg_pkg::ADDR_PLL: rdWord = pll_r;
      serdes_cfg_pkg::ADDR_STATUS: rdWord = serdes_cfg_pkg::STATUS_FIXED;
      serdes_cfg_pkg::ADDR_FAIL: rdWord = fail_r;
      serdes_cfg_pkg::ADDR_REDUN: rdWord = redun_r;
      default: rdWord = 16'h0000;
    endcase
  end

  // frame engine, advanced once per synchronised mdc rise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mdcPrev_r <= 1'b0;
      state_r <= PRE;
      preCnt_r <= '0;
      bitCnt_r <= '0;
      shift_r <= '0;
      rdShift_r <= '0;
      op_r <= '0;
      addr_r <= '0;
      mdioOut <= 1'b1;
      mdioOe <= 1'b0;
    end else begin
      mdcPrev_r <= mdcS;
      if (mdcRise) begin
        unique case (state_r)
          PRE: begin
            if (mdioS) begin
              if (preCnt_r != serdes_cfg_pkg::PREAMBLE_LEN) preCnt_r <= preCnt_r + 6'h01;
            end else if (preCnt_r == serdes_cfg_pkg::PREAMBLE_LEN) begin
              state_r <= HDR;
              bitCnt_r <= 5'h01;
              shift_r <= '0;
            end else begin
              preCnt_r <= '0;
            end
          end
          HDR: begin
            shift_r <= wrData;
            bitCnt_r <= bitCnt_r + 5'h01;
            if (bitCnt_r == serdes_cfg_pkg::HDR_LAST) begin
              bitCnt_r <= '0;
              preCnt_r <= '0;
              op_r <= hdrWord[11:10];
              rdShift_r <= rdWord;
              state_r <= hdrMatch ? TURN : PRE;
            end
          end
          TURN: begin
            bitCnt_r <= bitCnt_r + 5'h01;
            if (op_r[1] && bitCnt_r == 5'h00) begin
              mdioOe <= 1'b1;
              mdioOut <= 1'b0;
            end
            if (bitCnt_r == 5'h01) begin
              state_r <= DATA;
              bitCnt_r <= '0;
              if (op_r[1]) begin
                mdioOut <= rdShift_r[15];
                rdShift_r <= {rdShift_r[14:0], 1'b0};
              end
            end
          end
          DATA: begin
            shift_r <= wrData;
            bitCnt_r <= bitCnt_r + 5'h01;
            if (op_r[1]) begin
              mdioOut <= rdShift_r[15];
              rdShift_r <= {rdShift_r[14:0], 1'b0};
            end
            if (bitCnt_r == serdes_cfg_pkg::DATA_LAST) begin
              state_r <= PRE;
              mdioOe <= 1'b0;
              mdioOut <= 1'b1;
              if (op_r == serdes_cfg_pkg::OP_ADDR) addr_r <= wrData;
              if (op_r == serdes_cfg_pkg::OP_RDINC) addr_r <= addr_r + 16'h0001;
            end
          end
        endcase
      end
    end
  end

  // reserved codes are refused: the field keeps its previous value
  assign rateNxt = (wrData[14:13] == serdes_cfg_pkg::RATE_RESERVED) ? cfg2_r[14:13] : wrData[14:13];
  assign mulNxt = (wrData[10:8] == serdes_cfg_pkg::MUL_RESERVED) ? cfg2_r[10:8] : wrData[10:8];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= serdes_cfg_pkg::CTRL_RESET;
      cfg2_r <= serdes_cfg_pkg::CFG2_RESET;
      laneEn_r <= serdes_cfg_pkg::LANE_EN_RESET;
      pll_r <= serdes_cfg_pkg::PLL_RESET;
      fail_r <= serdes_cfg_pkg::FAIL_RESET;
      redun_r <= serdes_cfg_pkg::REDUN_RESET;
    end else if (wrEn) begin
      if (addr_r == serdes_cfg_pkg::ADDR_CTRL) ctrl_r <= wrData & serdes_cfg_pkg::CTRL_MASK;
      if (addr_r == serdes_cfg_pkg::ADDR_CFG2)
        cfg2_r <= {wrData[15], rateNxt, wrData[12:11], mulNxt, 8'h00} & serdes_cfg_pkg::CFG2_MASK;
      if (addr_r == serdes_cfg_pkg::ADDR_LANE_EN) laneEn_r <= wrData;
      if (addr_r == serdes_cfg_pkg::ADDR_PLL) pll_r <= wrData & serdes_cfg_pkg::PLL_MASK;
      if (addr_r == serdes_cfg_pkg::ADDR_FAIL) fail_r <= wrData & serdes_cfg_pkg::FAIL_MASK;
      if (addr_r == serdes_cfg_pkg::ADDR_REDUN) redun_r <= wrData & serdes_cfg_pkg::REDUN_MASK;
    end
  end

  assign jogModeSelect = cfg2_r[serdes_cfg_pkg::JOG_BIT];
  assign serialRateSelect = cfg2_r[serdes_cfg_pkg::RATE_LO+:2];
  assign byteWidthSelect = cfg2_r[serdes_cfg_pkg::WIDTH_BIT];
  assign loopBandwidthLow = cfg2_r[serdes_cfg_pkg::LBW_BIT];
  assign multiplierSelect = cfg2_r[serdes_cfg_pkg::MUL_LO+:3];
  assign pllEnable = pll_r[serdes_cfg_pkg::PLL_EN_BIT];
  assign serdesPowerDown = ctrl_r[serdes_cfg_pkg::CTRL_PD_BIT];
  assign primarySideA = redun_r[serdes_cfg_pkg::PRIMARY_BIT];
  assign commaAlignEn = commaAlignEn_r;
  assign alignJog = alignJog_r;
  assign multFactor = multFactor_r;
  assign failOut = failOut_r;

  // in jog mode the alignment enables hold their last level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      jogPrev_r <= '0;
      commaAlignEn_r <= '0;
      alignJog_r <= '0;
      multFactor_r <= '0;
      failOut_r <= 1'b0;
    end else begin
      jogPrev_r <= jogS;
      commaAlignEn_r <= jogModeSelect ? commaAlignEn_r : jogS;
      alignJog_r <= jogModeSelect ? (jogS & ~jogPrev_r) : 8'h00;
      multFactor_r <= mulFactor(multiplierSelect);
      failOut_r <= fail_r[serdes_cfg_pkg::FAIL_SEL_BIT] ? testFailSrc[1] : testFailSrc[0];
    end
  end

  lane_power_gate #(.LANES(8)) uGate (
    .clk(clk),
    .sys_rst(sys_rst),
    .laneEnable(laneEn_r),
    .globalPd(serdesPowerDown),
    .sidePdA(ctrl_r[serdes_cfg_pkg::CTRL_PD_A_BIT]),
    .sidePdB(ctrl_r[serdes_cfg_pkg::CTRL_PD_B_BIT]),
    .txPairEn(txPairEn),
    .rxPairEn(rxPairEn)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence readTurnStart;
    mdcRise && state_r == TURN && bitCnt_r == 5'h00 && op_r[1];
  endsequence

  sequence rdIncLast;
    mdcRise && state_r == DATA && bitCnt_r == serdes_cfg_pkg::DATA_LAST && op_r == serdes_cfg_pkg::OP_RDINC;
  endsequence

  a_jog_level: assert property (!jogModeSelect |=> commaAlignEn_r == $past(jogS) && alignJog_r == 8'h00)
    else $error("alignment enable does not follow jog input");
  a_jog_pulse: assert property (alignJog_r != 8'h00 |=> (alignJog_r & $past(alignJog_r)) == 8'h00)
    else $error("jog request longer than one cycle");
  a_rate_reserved: assert property (serialRateSelect != serdes_cfg_pkg::RATE_RESERVED)
    else $error("reserved rate code stored");
  a_mult_reserved: assert property (multiplierSelect != serdes_cfg_pkg::MUL_RESERVED)
    else $error("reserved multiplier code stored");
  a_cfg_reset: assert property ($fell(sys_rst) |-> cfg2_r == serdes_cfg_pkg::CFG2_RESET)
    else $error("config register reset value wrong");
  a_fail_route: assert property (##1 failOut_r == $past(testFailSrc[fail_r[serdes_cfg_pkg::FAIL_SEL_BIT] ? 1 : 0]))
    else $error("fail output not routed by select");
  a_read_turn: assert property (readTurnStart |=> mdioOe && !mdioOut)
    else $error("read turnaround not driven low");
  a_write_hold: assert property (wrEn && addr_r == serdes_cfg_pkg::ADDR_LANE_EN |=> ##1 laneEn_r == $past(wrData, 2))
    else $error("lane enable register lost written value");

  // stored fields reach their outputs one cycle after the write lands
  a_cfg_write: assert property (wrEn && addr_r == serdes_cfg_pkg::ADDR_CFG2 |=>
    byteWidthSelect == $past(wrData[serdes_cfg_pkg::WIDTH_BIT]) &&
    loopBandwidthLow == $past(wrData[serdes_cfg_pkg::LBW_BIT]))
    else $error("width or bandwidth bit not stored");
  a_primary_hold: assert property (!(wrEn && addr_r == serdes_cfg_pkg::ADDR_REDUN) |=>
    $stable(primarySideA))
    else $error("primary select moved without a write");
  // an idle engine must never fight the station for the line
  a_idle_released: assert property (state_r == PRE |-> !mdioOe)
    else $error("data line driven outside a read");
  a_addr_step: assert property (rdIncLast |=> addr_r == $past(addr_r) + 16'h0001)
    else $error("read-increment did not step the address");
endmodule

// *** verilog/serdes_cfg_pkg.sv ***
// constants for the serdes configuration register bank
// assumes a clause 45 management frame engine in front of the registers
package serdes_cfg_pkg;
  localparam logic [15:0] ADDR_CTRL = 16'h0000;
  localparam logic [15:0] ADDR_CFG2 = 16'h8085;
  localparam logic [15:0] ADDR_LANE_EN = 16'h8086;
  localparam logic [15:0] ADDR_PLL = 16'h8087;
  localparam logic [15:0] ADDR_STATUS = 16'h8088;
  localparam logic [15:0] ADDR_FAIL = 16'h8089;
  localparam logic [15:0] ADDR_REDUN = 16'h808B;

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CFG2_RESET = 16'h0A00;
  localparam logic [15:0] LANE_EN_RESET = 16'hFFFF;
  localparam logic [15:0] PLL_RESET = 16'h8000;
  localparam logic [15:0] FAIL_RESET = 16'h8000;
  localparam logic [15:0] REDUN_RESET = 16'h0000;
  localparam logic [15:0] STATUS_FIXED = 16'h0000;

  localparam logic [15:0] CTRL_MASK = 16'h0803;
  localparam logic [15:0] CFG2_MASK = 16'hFF00;
  localparam logic [15:0] PLL_MASK = 16'h8000;
  localparam logic [15:0] FAIL_MASK = 16'h8000;
  localparam logic [15:0] REDUN_MASK = 16'h0008;

  localparam int CTRL_PD_BIT = 11;
  localparam int CTRL_PD_A_BIT = 0;
  localparam int CTRL_PD_B_BIT = 1;
  localparam int JOG_BIT = 15;
  localparam int RATE_LO = 13;
  localparam int WIDTH_BIT = 12;
  localparam int LBW_BIT = 11;
  localparam int MUL_LO = 8;
  localparam int PLL_EN_BIT = 15;
  localparam int FAIL_SEL_BIT = 15;
  localparam int PRIMARY_BIT = 3;
  localparam int TX_LO = 8;
  localparam int RX_LO = 0;

  localparam logic [1:0] RATE_RESERVED = 2'h3;
  localparam logic [2:0] MUL_RESERVED = 3'h7;

  localparam logic [4:0] DEVAD_A = 5'h04;
  localparam logic [4:0] DEVAD_B = 5'h05;
  localparam logic [1:0] OP_ADDR = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_RDINC = 2'h2;
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [4:0] HDR_LAST = 5'h0D;
  localparam logic [4:0] DATA_LAST = 5'h0F;
endpackage

// *** verilog/pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins; output moves only when stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 10
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] agree;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs at least one bit");
  end

  assign agree = ~(s2_r ^ s3_r);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      pinOut <= '0;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pinOut <= (agree & s2_r) | (~agree & pinOut);
    end
  end
endmodule

// *** verilog/lane_power_gate.sv ***
// per-lane transmit and receive pair enables after power-down gating
// assumes enables and power-down levels come from registers on clk
`timescale 1ns/1ps
module lane_power_gate #(
  parameter int LANES = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2*LANES-1:0] laneEnable,
  input wire logic globalPd,
  input wire logic sidePdA,
  input wire logic sidePdB,
  output logic [LANES-1:0] txPairEn,
  output logic [LANES-1:0] rxPairEn
);
  localparam int HALF = LANES / 2;
  logic [LANES-1:0] laneOff;

  if (LANES % 2 != 0 || LANES < 2) begin : g_bad_lanes
    $error("lane count must be even");
  end

  // side a owns the low half of the lanes, side b the high half
  for (genvar i = 0; i < LANES; i++) begin : g_off
    assign laneOff[i] = globalPd | ((i < HALF) ? sidePdA : sidePdB);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txPairEn <= '1;
      rxPairEn <= '1;
    end else begin
      txPairEn <= laneEnable[2*LANES-1:LANES] & ~laneOff;
      rxPairEn <= laneEnable[LANES-1:0] & ~laneOff;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_global_pd_off: assert property (globalPd |=> txPairEn == '0 && rxPairEn == '0)
    else $error("lanes stay enabled under global power-down");
  a_side_a_off: assert property (sidePdA |=> txPairEn[HALF-1:0] == '0 && rxPairEn[HALF-1:0] == '0)
    else $error("side a lanes stay enabled under side power-down");
  a_side_b_off: assert property (sidePdB |=> txPairEn[LANES-1:HALF] == '0 && rxPairEn[LANES-1:HALF] == '0)
    else $error("side b lanes stay enabled under side power-down");
  a_lane_follow: assert property (!globalPd && !sidePdA && !sidePdB |=>
    txPairEn == $past(laneEnable[2*LANES-1:LANES]) && rxPairEn == $past(laneEnable[LANES-1:0]))
    else $error("lane enables do not follow the enable register");
endmodule

// *** verification/mdio_station.sv ***
// management station model driving frames on mdc and mdio
// assumes the device samples mdio on mdc rise; mdio has a pull-up
`timescale 1ns/1ps
module mdio_station #(
  parameter logic [4:0] PORT_ADDR = 5'h00
) (
  input wire logic clk,
  output logic mdc,
  output logic mdioWire,
  input wire logic mdioOut,
  input wire logic mdioOe
);
  logic drvEn;
  logic drvVal;

  // pull-up wins when nobody drives the line
  assign mdioWire = mdioOe ? mdioOut : (drvEn ? drvVal : 1'b1);

  initial begin
    mdc = 1'b0;
    drvEn = 1'b0;
    drvVal = 1'b1;
  end

  // mdc period of 16 clk, well above the fastest spacing the device accepts
  task automatic bit_cycle(input logic en, input logic val, output logic smp);
    drvEn = en;
    drvVal = val;
    mdc = 1'b0;
    repeat (8) @(posedge clk);
    #2;
    smp = mdioWire;
    mdc = 1'b1;
    repeat (8) @(posedge clk);
    #2;
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] devad, input logic [15:0] data,
                       output logic [15:0] rd);
    logic [31:0] seq;
    logic smp;
    seq = {2'b00, op, PORT_ADDR, devad, 2'b10, data};
    rd = 16'h0000;
    @(posedge clk);
    #2;
    for (int i = 0; i < 32; i++) begin
      bit_cycle(1'b1, 1'b1, smp);
    end
    // reads hand the line over from the turnaround on
    for (int i = 31; i >= 0; i--) begin
      bit_cycle(!(op[1] && i < 18), seq[i], smp);
      if (i < 16) begin
        rd[i] = smp;
      end
    end
    drvEn = 1'b0;
  endtask
endmodule

// *** verification/tb_top.sv ***
// self-checking bench for the serdes configuration register bank
// assumes mdio_station as the only management master
`timescale 1ns/1ps
module tb_top;
  logic clk, sysRst, mdc, mdioWire, mdioOut, mdioOe, jogModeSelect, byteWidthSelect, loopBandwidthLow;
  logic pllEnable, serdesPowerDown, primarySideA, failOut;
  logic [7:0] perLaneAlignControl, commaAlignEn, alignJog, txPairEn, rxPairEn;
  logic [1:0] testFailSrc, serialRateSelect;
  logic [2:0] multiplierSelect;
  logic [4:0] multFactor;
  int errors, checkCount;

  serdes_config_register_bank i_dut (.clk(clk), .sys_rst(sysRst), .mdc(mdc), .mdioIn(mdioWire),
    .mdioOut(mdioOut), .mdioOe(mdioOe), .perLaneAlignControl(perLaneAlignControl),
    .testFailSrc(testFailSrc), .commaAlignEn(commaAlignEn), .alignJog(alignJog),
    .jogModeSelect(jogModeSelect), .serialRateSelect(serialRateSelect), .byteWidthSelect(byteWidthSelect),
    .loopBandwidthLow(loopBandwidthLow), .multiplierSelect(multiplierSelect), .multFactor(multFactor),
    .pllEnable(pllEnable), .serdesPowerDown(serdesPowerDown), .txPairEn(txPairEn), .rxPairEn(rxPairEn),
    .primarySideA(primarySideA), .failOut(failOut));
  mdio_station i_sta (.clk(clk), .mdc(mdc), .mdioWire(mdioWire), .mdioOut(mdioOut), .mdioOe(mdioOe));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [15:0] addr, input logic [15:0] data,
                        input logic [4:0] devad = serdes_cfg_pkg::DEVAD_A);
    logic [15:0] d;
    i_sta.frame(serdes_cfg_pkg::OP_ADDR, devad, addr, d);
    i_sta.frame(serdes_cfg_pkg::OP_WRITE, devad, data, d);
  endtask

  task automatic reg_rd(input logic [15:0] addr, output logic [15:0] data);
    logic [15:0] d;
    i_sta.frame(serdes_cfg_pkg::OP_ADDR, serdes_cfg_pkg::DEVAD_A, addr, d);
    i_sta.frame(2'h3, serdes_cfg_pkg::DEVAD_A, 16'h0000, data);
  endtask

  task automatic t_reset;
    logic [15:0] a[5] = '{16'h8085, 16'h8086, 16'h8087, 16'h8088, 16'h8089};
    logic [15:0] e[5] = '{16'h0A00, 16'hFFFF, 16'h8000, 16'h0000, 16'h8000};
    logic [15:0] v;
    for (int i = 0; i < 5; i++) begin
      reg_rd(a[i], v);
      check("reset value", v, e[i]);
    end
    check("cfg outputs", 16'({jogModeSelect, serialRateSelect, byteWidthSelect, loopBandwidthLow,
      multiplierSelect}), 16'h000A);
    check("factor", 16'(multFactor), 16'h000A);
    check("pairs", {txPairEn, rxPairEn}, 16'hFFFF);
    check("pll enable", 16'(pllEnable), 16'h0001);
  endtask

  task automatic t_cfg2;
    logic [4:0] fac[7] = '{5'h05, 5'h19, 5'h0A, 5'h0F, 5'h04, 5'h14, 5'h08};
    logic [7:0] w;
    logic [15:0] v;
    for (int i = 0; i < 7; i++) begin
      w = {1'b0, 2'(i % 3), i[0], i[1], i[2:0]};
      reg_wr(16'h8085, {w, 8'h00});
      check("factor", 16'(multFactor), 16'(fac[i]));
      check("cfg fields", 16'({jogModeSelect, serialRateSelect, byteWidthSelect, loopBandwidthLow,
        multiplierSelect}), 16'(w));
    end
    // reserved codes leave rate and multiplier as they were
    reg_wr(16'h8085, 16'h7F00);
    reg_rd(16'h8085, v);
    check("reserved codes", v, 16'h1E00);
    reg_wr(16'h8085, 16'h0A00);
  endtask

  task automatic t_lanes;
    logic [15:0] ctl[4] = '{16'h0001, 16'h0002, 16'h0800, 16'h0000};
    logic [15:0] e[4] = '{16'h50C0, 16'h0A03, 16'h0000, 16'h5AC3};
    logic [15:0] v;
    reg_wr(16'h8086, 16'h5AC3);
    check("pairs", {txPairEn, rxPairEn}, 16'h5AC3);
    for (int i = 0; i < 4; i++) begin
      reg_wr(16'h0000, ctl[i]);
      check("gated pairs", {txPairEn, rxPairEn}, e[i]);
      check("power-down", 16'(serdesPowerDown), 16'(ctl[i][11]));
      reg_rd(16'h8086, v);
      check("lane enable kept", v, 16'h5AC3);
    end
    reg_wr(16'h8086, 16'hFFFF);
  endtask

  task automatic t_status;
    logic [15:0] v;
    reg_wr(16'h8088, 16'hFFFF);
    reg_rd(16'h8088, v);
    check("status", v, 16'h0000);
    reg_rd(16'h8090, v);
    check("unmapped", v, 16'h0000);
    // read-increment steps the shared address on to the pll register
    i_sta.frame(serdes_cfg_pkg::OP_ADDR, serdes_cfg_pkg::DEVAD_A, 16'h8086, v);
    i_sta.frame(serdes_cfg_pkg::OP_RDINC, serdes_cfg_pkg::DEVAD_A, 16'h0000, v);
    check("read-inc data", v, 16'hFFFF);
    i_sta.frame(2'h3, serdes_cfg_pkg::DEVAD_A, 16'h0000, v);
    check("read-inc next", v, 16'h8000);
  endtask

  task automatic t_jog;
    logic [7:0] seen;
    int cnt;
    @(posedge clk);
    #2 perLaneAlignControl = 8'hA5;
    repeat (10) @(posedge clk);
    check("align enable", 16'(commaAlignEn), 16'h00A5);
    reg_wr(16'h8085, 16'h8A00);
    seen = 8'h00;
    cnt = 0;
    @(posedge clk);
    #2 perLaneAlignControl = 8'hA7;
    // the jog pulse must appear within 12 clk of the input change
    repeat (12) begin
      @(posedge clk);
      #1;
      seen |= alignJog;
      cnt += int'(alignJog != 8'h00);
    end
    check("jog lanes", 16'(seen), 16'h0002);
    check("jog width", 16'(cnt), 16'h0001);
    check("align held", 16'(commaAlignEn), 16'h00A5);
    reg_wr(16'h8085, 16'h0A00);
  endtask

  task automatic t_fail;
    logic [1:0] src[4] = '{2'b01, 2'b10, 2'b10, 2'b01};
    logic e[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        reg_wr(16'h8089, 16'h0000);
      end
      @(posedge clk);
      #2 testFailSrc = src[i];
      repeat (3) @(posedge clk);
      check("fail output", 16'(failOut), 16'(e[i]));
    end
  endtask

  task automatic t_primary;
    logic [15:0] v;
    check("primary reset", 16'(primarySideA), 16'h0000);
    reg_wr(16'h808B, 16'h0008, serdes_cfg_pkg::DEVAD_B);
    check("primary a", 16'(primarySideA), 16'h0001);
    reg_rd(16'h808B, v);
    check("primary readback", v, 16'h0008);
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // about 70 frames of 1025 clk each; the limit leaves some slack
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    errors = 0;
    checkCount = 0;
    sysRst = 1'b1;
    perLaneAlignControl = 8'h00;
    testFailSrc = 2'b00;
    repeat (12) @(posedge clk);
    #2 sysRst = 1'b0;
    t_reset();
    t_primary();
    t_cfg2();
    t_lanes();
    t_status();
    t_jog();
    t_fail();
    summarize();
  end
endmodule
